//--- logic/fecs_pkg.sv
// Package for the flash erase control sequencer.
// Assumes a 250 MHz bus clock and a 16-bit CPU address space.
package fecs_pkg;

    // ******************************
    // Bus and array geometry
    // ******************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int ARRAY_BYTES = 16384;
    localparam int IDX_W = 14;
    localparam int PAGE_BYTES = 64;
    localparam int ROW_BYTES = 32;
    localparam int PAGE_LSB = 6;

    // ******************************
    // Address map
    // ******************************
    localparam logic [15:0] ARRAY_BASE = 16'hc000;
    localparam logic [15:0] USER_START_LARGE = 16'hc000;
    localparam logic [15:0] USER_START_SMALL = 16'he000;
    localparam logic [15:0] USER_END = 16'hfdff;
    localparam logic [15:0] FLASH_CONTROL_ADDR = 16'hfe08;
    localparam logic [15:0] FLASH_PROTECT_START_ADDR = 16'hff7e;
    localparam logic [15:0] TRIM_STORE_HIGH_SUPPLY_ADDR = 16'hff80;
    localparam logic [15:0] TRIM_STORE_LOW_SUPPLY_ADDR = 16'hff81;
    localparam logic [15:0] VECTOR_BASE = 16'hffdc;
    localparam logic [15:0] VECTOR_PAGE = 16'hffc0;
    localparam logic [1:0] PROTECT_TOP_BITS = 2'b11;
    localparam logic [5:0] PROTECT_LOW_BITS = 6'h00;

    // ******************************
    // Control register fields and values
    // ******************************
    localparam int CTL_PGM_BIT = 0;
    localparam int CTL_ERASE_BIT = 1;
    localparam int CTL_MASS_BIT = 2;
    localparam int CTL_HV_BIT = 3;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] PROTECT_NONE = 8'hff;
    localparam logic [7:0] BLOCKED_READ = 8'hff;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ******************************
    // Timing
    // ******************************
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SETUP_BEFORE_HIGH_VOLTAGE_NS = 10000;
    localparam int READ_RECOVERY_TIME_NS = 1000;
    localparam int SETUP_CYC =
        (SETUP_BEFORE_HIGH_VOLTAGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RECOVERY_CYC = READ_RECOVERY_TIME_NS * 1000 / CLK_PERIOD_PS;
    localparam int SETUP_W = 12;
    localparam int RECOV_W = 8;

    // ******************************
    // Sequence states
    // ******************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SELECTED = 5'b00010,
        ST_CHECKED = 5'b00100,
        ST_ARMED = 5'b01000,
        ST_HIGH_V = 5'b10000
    } fecs_state_e;

endpackage

//--- logic/fecs_top.sv
// Flash erase control sequencer: control register, interlocks, page and
// whole-array erase, protection gating and a flip-flop model of the array.
// Assumes a CPU master on the plain strobe port, same clock domain.
`timescale 1ns/100ps

// Contract
// R1 - Erased bits read 1, programmed bits read 0.
// R2 - Pages are 64 bytes of two 32-byte rows; erase unit is a page.
// R3 - User array 15,872 or 7,680 bytes, plus vectors, protect and trims.
// R4 - Decode array, control, protect, trims and vectors at fixed addresses.
// R5 - High voltage sets only with a select bit and the proper sequence.
// R6 - High voltage bit drives pump and array high voltage.
// R7 - Whole-array select makes an erase act on the whole array.
// R8 - Erase select configures an erase.
// R9 - Program select configures a program.
// R10 - Erase and program selects never both 1; such writes rejected.
// R11 - Pages are 64-byte aligned; vector area is a page; each erasable alone.
// R12 - Software sets erase, reads protect, writes inside the target page.
// R13 - Software waits 10 us, sets high voltage, holds 1 ms or 4 ms.
// R14 - Software clears erase, waits 5 us, clears high voltage.
// R15 - Software picks 4 ms erase above 1000 cycles.
// R16 - Erasing vector page or whole array also erases both trim bytes.
// R17 - Software sets erase and whole-array, reads protect, writes array.
// R18 - In failed-security monitor mode the write goes to the protect byte.
// R19 - Whole-array: 10 us setup, 4 ms hold, clear selects, 100 us, clear.
// R20 - Whole-array erase blocked unless protect byte is all ones.
// R21 - Steps in order; not run from the same array.
// R22 - High voltage refused when the addressed region is protected.
// R23 - Page address latched from first array write after select.
// R24 - Array reads blocked under high voltage and until recovery ends.
module fecs_top
    import fecs_pkg::*;
#(
    parameter bit SMALL_VARIANT = 1'b0,
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int RECOVERY_CYCLES = RECOVERY_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Register bus
    input wire logic [fecs_pkg::ADDR_W-1:0] addr_i,
    input wire logic [fecs_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [fecs_pkg::DATA_W-1:0] rdata_o,
    // Array control
    output logic pump_on_o,
    output logic array_hv_o,
    output logic erase_sel_o,
    output logic mass_sel_o,
    output logic prog_sel_o,
    output logic read_block_o
);
    import fecs_pkg::*;

    // ******************************
    // Storage
    // ******************************
    // Flip-flop array, one byte per address above the array base
    logic [7:0] mem_q [ARRAY_BYTES];
    logic hv_q, hv_d;
    logic erase_q, erase_d;
    logic mass_q, mass_d;
    logic pgm_q, pgm_d;
    // Latched page address and the two wait counters
    logic [15:0] lat_q, lat_d;
    logic [SETUP_W-1:0] setup_q, setup_d;
    logic [RECOV_W-1:0] recov_q, recov_d;
    logic [7:0] rdata_d;
    logic blk_q;
    fecs_state_e st_q, st_d;

    // ******************************
    // Address decode
    // ******************************
    wire [15:0] user_start = SMALL_VARIANT ? USER_START_SMALL : USER_START_LARGE;
    wire [IDX_W-1:0] idx = addr_i[IDX_W-1:0];
    wire hit_ctl = addr_i == FLASH_CONTROL_ADDR; // [R4]
    wire hit_prot = addr_i == FLASH_PROTECT_START_ADDR;
    wire hit_trim = addr_i == TRIM_STORE_HIGH_SUPPLY_ADDR ||
        addr_i == TRIM_STORE_LOW_SUPPLY_ADDR;
    wire hit_user = addr_i >= user_start && addr_i <= USER_END; // [R3]
    wire hit_vec = addr_i >= VECTOR_BASE; // [R4]
    // Array covers user space, protect byte, trims and vectors
    wire hit_arr = hit_user || hit_prot || hit_trim || hit_vec;

    // ******************************
    // Protection decode
    // ******************************
    // Protected range runs from the start address to the top of the array;
    // an all-ones protect byte leaves everything open
    wire [7:0] prot_byte = mem_q[FLASH_PROTECT_START_ADDR[IDX_W-1:0]];
    wire [15:0] prot_start = {PROTECT_TOP_BITS, prot_byte, PROTECT_LOW_BITS};
    wire prot_none = prot_byte == PROTECT_NONE;
    wire lat_protected = !prot_none && lat_q >= prot_start; // [R22]
    wire mass_blocked = !prot_none; // [R20]

    // ******************************
    // Control write decode
    // ******************************
    wire ctl_wr = wr_i && hit_ctl;
    wire n_pgm = wdata_i[CTL_PGM_BIT];
    wire n_erase = wdata_i[CTL_ERASE_BIT];
    wire n_mass = wdata_i[CTL_MASS_BIT];
    wire n_hv = wdata_i[CTL_HV_BIT];
    // A write with both selects set is dropped as a whole
    wire both_sel = n_pgm && n_erase; // [R10]
    wire ctl_ok = ctl_wr && !both_sel; // [R10]
    // High voltage needs the armed state, an elapsed setup wait, a select bit
    // in the same write and an unprotected target
    wire hv_allowed = st_q == ST_ARMED && setup_q == '0 && (n_pgm || n_erase) &&
        !lat_protected && !(n_erase && n_mass && mass_blocked); // [R5] [R22] [R20]
    wire hv_rise = ctl_ok && n_hv && !hv_q && hv_allowed;
    wire hv_fall = ctl_ok && !n_hv && hv_q;
    wire arr_wr = wr_i && hit_arr;
    wire prot_rd = rd_i && hit_prot;

    // ******************************
    // Erase and program strobes
    // ******************************
    wire mass_go = hv_rise && n_erase && n_mass; // [R7]
    wire page_go = hv_rise && n_erase && !n_mass; // [R8] [R11]
    // Vector page erase also clears the trim bytes
    wire vec_page = {lat_q[15:PAGE_LSB], PROTECT_LOW_BITS} == VECTOR_PAGE;
    wire prog_go = arr_wr && st_q == ST_HIGH_V && pgm_q && hv_q; // [R9]

    // Control register next values
    always_comb begin
        erase_d = erase_q;
        mass_d = mass_q;
        pgm_d = pgm_q;
        hv_d = hv_q;
        if (ctl_ok) begin
            erase_d = n_erase; // [R8]
            mass_d = n_mass; // [R7]
            pgm_d = n_pgm; // [R9]
            if (hv_rise) begin
                hv_d = 1'b1; // [R5]
            // Clear of high voltage is taken on any control write that does not set both selects
            end else if (!n_hv) begin
                hv_d = 1'b0;
            end
        end
    end

    // Sequence tracking and address latch
    always_comb begin
        st_d = st_q;
        lat_d = lat_q;
        setup_d = setup_q;
        if (setup_q != '0) begin
            setup_d = setup_q - 1'b1;
        end
        case (st_q)
            ST_IDLE: begin
                // Waits for a select bit while high voltage is off
                if (ctl_ok && (n_erase || n_pgm) && !hv_q) begin
                    st_d = ST_SELECTED;
                end
            end
            ST_SELECTED: begin
                // Protect read must come before the latching write
                if (ctl_ok && !n_erase && !n_pgm) begin
                    st_d = ST_IDLE;
                end else if (prot_rd) begin
                    st_d = ST_CHECKED; // [R5]
                end
            end
            ST_CHECKED: begin
                // First array write latches the page and starts the setup wait
                if (ctl_ok && !n_erase && !n_pgm) begin
                    st_d = ST_IDLE;
                end else if (arr_wr) begin
                    st_d = ST_ARMED;
                    lat_d = addr_i; // [R23]
                    setup_d = SETUP_W'(SETUP_CYCLES);
                end
            end
            ST_ARMED: begin
                // Clearing both selects abandons the sequence
                if (hv_rise) begin
                    st_d = ST_HIGH_V; // [R5]
                end else if (ctl_ok && !n_erase && !n_pgm) begin
                    st_d = ST_IDLE;
                end
            end
            ST_HIGH_V: begin
                // Only a clear of high voltage ends the operation
                if (hv_fall) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // Recovery counter after high voltage drops
    // Reads stay blocked until this count runs out
    always_comb begin
        recov_d = recov_q;
        if (hv_fall) begin
            recov_d = RECOV_W'(RECOVERY_CYCLES);
        end else if (recov_q != '0) begin
            recov_d = recov_q - 1'b1;
        end
    end

    // Read data selection
    always_comb begin
        rdata_d = UNMAPPED_READ;
        if (hit_ctl) begin
            // Control bits read back in place, upper bits read zero
            rdata_d = '0;
            rdata_d[CTL_HV_BIT] = hv_q;
            rdata_d[CTL_MASS_BIT] = mass_q;
            rdata_d[CTL_ERASE_BIT] = erase_q;
            rdata_d[CTL_PGM_BIT] = pgm_q;
        end else if (hit_arr) begin
            // Array reads give all ones while blocked
            if (hv_q || recov_q != '0) begin
                rdata_d = BLOCKED_READ; // [R24]
            end else begin
                rdata_d = mem_q[idx]; // [R1]
            end
        end
    end

    // Control and sequence registers
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            hv_q <= CTL_RESET[CTL_HV_BIT];
            erase_q <= CTL_RESET[CTL_ERASE_BIT];
            mass_q <= CTL_RESET[CTL_MASS_BIT];
            pgm_q <= CTL_RESET[CTL_PGM_BIT];
            st_q <= ST_IDLE;
            lat_q <= '0;
            setup_q <= '0;
            recov_q <= '0;
        end else begin
            hv_q <= hv_d;
            erase_q <= erase_d;
            mass_q <= mass_d;
            pgm_q <= pgm_d;
            st_q <= st_d;
            lat_q <= lat_d;
            setup_q <= setup_d;
            recov_q <= recov_d;
        end
    end

    // Output registers
    // Outputs follow the next values so they line up with the internal bits
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rdata_o <= '0;
            pump_on_o <= 1'b0;
            array_hv_o <= 1'b0;
            erase_sel_o <= 1'b0;
            mass_sel_o <= 1'b0;
            prog_sel_o <= 1'b0;
            blk_q <= 1'b0;
        end else begin
            rdata_o <= rd_i ? rdata_d : '0;
            pump_on_o <= hv_d; // [R6]
            array_hv_o <= hv_d; // [R6]
            erase_sel_o <= erase_d;
            mass_sel_o <= mass_d;
            prog_sel_o <= pgm_d;
            blk_q <= hv_d || recov_d != '0; // [R24]
        end
    end
    assign read_block_o = blk_q;

    // Array cells: erase sets whole pages to ones, program only clears bits
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                mem_q[i] <= ERASED_BYTE; // [R1]
            end
        end else begin
            for (int i = 0; i < ARRAY_BYTES; i++) begin
                if (mass_go) begin
                    mem_q[i] <= ERASED_BYTE; // [R7] [R16]
                // Page match compares the index above the page offset
                end else if (page_go &&
                    (IDX_W-PAGE_LSB)'(i >> PAGE_LSB) == lat_q[IDX_W-1:PAGE_LSB]) begin
                    mem_q[i] <= ERASED_BYTE; // [R2] [R11] [R23]
                end else if (page_go && vec_page &&
                    (IDX_W'(i) == TRIM_STORE_HIGH_SUPPLY_ADDR[IDX_W-1:0] ||
                     IDX_W'(i) == TRIM_STORE_LOW_SUPPLY_ADDR[IDX_W-1:0])) begin
                    mem_q[i] <= ERASED_BYTE; // [R16]
                end
            end
            // Program ANDs the data in, so bits only fall
            if (prog_go) begin
                mem_q[idx] <= mem_q[idx] & wdata_i; // [R1] [R9]
            end
        end
    end

endmodule // fecs_top

//--- test/fecs_top_assertions.sv
// Port checker for the flash erase control sequencer.
// Assumes one clock domain and a bind onto fecs_top.
`timescale 1ns/100ps
module fecs_chk
    import fecs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Register bus
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    // Array control
    input wire logic pump_on_o,
    input wire logic array_hv_o,
    input wire logic erase_sel_o,
    input wire logic mass_sel_o,
    input wire logic prog_sel_o,
    input wire logic read_block_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // Control register write decode
    wire ctl_wr = wr_i && addr_i == FLASH_CONTROL_ADDR;
    wire hv_wr = ctl_wr && wdata_i[CTL_HV_BIT];
    wire user_rd = rd_i && addr_i >= ARRAY_BASE && addr_i <= USER_END;

    // ******************************
    // Checks
    // ******************************
    hv_pair_a: assert property (pump_on_o == array_hv_o)
        else $error("pump and array high voltage differ");
    sel_excl_a: assert property (!(erase_sel_o && prog_sel_o))
        else $error("erase and program selects both set");
    both_ignored_a: assert property (ctl_wr && wdata_i[1:0] == 2'b11 |=>
        $stable(erase_sel_o) && $stable(prog_sel_o) && $stable(mass_sel_o))
        else $error("write with both selects changed a bit");
    hv_cause_a: assert property ($rose(array_hv_o) |-> $past(hv_wr) &&
        (erase_sel_o || prog_sel_o))
        else $error("high voltage rose without a select or write");
    hv_clear_a: assert property (ctl_wr && !wdata_i[CTL_HV_BIT] &&
        !(wdata_i[CTL_PGM_BIT] && wdata_i[CTL_ERASE_BIT]) |=> !pump_on_o)
        else $error("high voltage kept after clearing write");
    hv_blocks_a: assert property (array_hv_o |-> read_block_o)
        else $error("reads open while high voltage on");
    blocked_read_a: assert property (user_rd && read_block_o |=> rdata_o == BLOCKED_READ)
        else $error("blocked array read not all ones");
    unmapped_rd_a: assert property (rd_i && addr_i < ARRAY_BASE |=>
        rdata_o == UNMAPPED_READ)
        else $error("unmapped read not zero");
    ctl_read_a: assert property (rd_i && addr_i == FLASH_CONTROL_ADDR |=> rdata_o ==
        {4'h0, $past(pump_on_o), $past(mass_sel_o), $past(erase_sel_o), $past(prog_sel_o)})
        else $error("control read differs from control outputs");
endmodule // fecs_chk

bind fecs_top fecs_chk u_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pump_on_o(pump_on_o),
    .array_hv_o(array_hv_o), .erase_sel_o(erase_sel_o), .mass_sel_o(mass_sel_o),
    .prog_sel_o(prog_sel_o), .read_block_o(read_block_o));

//--- test/tb_top.sv
// Self-checking bench for the flash erase control sequencer.
// Assumes short setup (4) and recovery (3) counts on the design.
`timescale 1ns/100ps
module tb_top;
    import fecs_pkg::*;
    // ******************************
    // Signals and device
    // ******************************
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic pump_on_o, array_hv_o, erase_sel_o, mass_sel_o, prog_sel_o, read_block_o;
    logic [7:0] pexp = 8'hff;
    int n_fail = 0;
    int checked = 0;

    fecs_top #(.SMALL_VARIANT(1'b0), .SETUP_CYCLES(4), .RECOVERY_CYCLES(3)) u_dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pump_on_o(pump_on_o),
        .array_hv_o(array_hv_o), .erase_sel_o(erase_sel_o), .mass_sel_o(mass_sel_o),
        .prog_sel_o(prog_sel_o), .read_block_o(read_block_o));

    // Bus clock, 4 ns period
    always #2 ref_clk_i = ~ref_clk_i;

    // ******************************
    // Compare and bus tasks
    // ******************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Control outputs against a control byte value
    task automatic chk_ctl(input logic [7:0] c);
        chk({3'h0, pump_on_o, array_hv_o, mass_sel_o, erase_sel_o, prog_sel_o},
            {3'h0, c[3], c[3:0]});
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    // Full sequence: select, protect read, latch, setup, try high voltage, close
    task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d,
                      input logic ok);
        wr(FLASH_CONTROL_ADDR, c);
        rd(FLASH_PROTECT_START_ADDR, pexp);
        wr(a, 8'h00);
        repeat (5) @(posedge ref_clk_i);
        wr(FLASH_CONTROL_ADDR, c | 8'h08);
        chk_ctl(ok ? (c | 8'h08) : c);
        if (c[0]) begin
            wr(a, d);
        end
        if (ok) begin
            rd(a, BLOCKED_READ);
        end
        wr(FLASH_CONTROL_ADDR, ok ? 8'h08 : 8'h00);
        wr(FLASH_CONTROL_ADDR, 8'h00);
        chk_ctl(8'h00);
        chk({7'h0, read_block_o}, {7'h0, ok});
        if (ok) begin
            rd(a, BLOCKED_READ);
        end
        repeat (5) @(posedge ref_clk_i);
        #1;
        chk({7'h0, read_block_o}, 8'h00);
        rd(a, c[0] ? d : ERASED_BYTE);
    endtask

    // ******************************
    // Scenarios
    // ******************************
    task automatic t_reset;
        chk_ctl(8'h00);
        rd(FLASH_CONTROL_ADDR, CTL_RESET);
        rd(16'hc000, ERASED_BYTE);
        rd(16'h0040, UNMAPPED_READ);
        rd(TRIM_STORE_LOW_SUPPLY_ADDR, ERASED_BYTE);
        $display("test reset done");
    endtask
    task automatic t_interlock;
        wr(FLASH_CONTROL_ADDR, 8'h01);
        wr(FLASH_CONTROL_ADDR, 8'h03);
        chk_ctl(8'h01);
        wr(FLASH_CONTROL_ADDR, 8'h09);
        chk_ctl(8'h01);
        wr(FLASH_CONTROL_ADDR, 8'h02);
        chk_ctl(8'h02);
        wr(FLASH_CONTROL_ADDR, 8'h06);
        rd(FLASH_CONTROL_ADDR, 8'h06);
        wr(FLASH_CONTROL_ADDR, 8'h00);
        $display("test interlock done");
    endtask
    task automatic t_program;
        op(8'h01, 16'hc040, 8'ha5, 1'b1);
        op(8'h01, 16'hc080, 8'h3c, 1'b1);
        op(8'h01, TRIM_STORE_HIGH_SUPPLY_ADDR, 8'h5a, 1'b1);
        rd(16'hc040, 8'ha5);
        rd(16'hc080, 8'h3c);
        rd(TRIM_STORE_HIGH_SUPPLY_ADDR, 8'h5a);
        $display("test program done");
    endtask
    task automatic t_page;
        op(8'h02, 16'hc07f, 8'h00, 1'b1);
        rd(16'hc040, ERASED_BYTE);
        rd(16'hc080, 8'h3c);
        op(8'h02, VECTOR_BASE, 8'h00, 1'b1);
        rd(TRIM_STORE_HIGH_SUPPLY_ADDR, ERASED_BYTE);
        $display("test page erase done");
    endtask
    task automatic t_protect;
        op(8'h01, FLASH_PROTECT_START_ADDR, 8'hfe, 1'b1);
        pexp = 8'hfe;
        op(8'h06, 16'hc000, 8'h00, 1'b0);
        op(8'h02, 16'hffe0, 8'h00, 1'b0);
        op(8'h02, FLASH_PROTECT_START_ADDR, 8'h00, 1'b1);
        pexp = 8'hff;
        rd(FLASH_PROTECT_START_ADDR, PROTECT_NONE);
        op(8'h06, FLASH_PROTECT_START_ADDR, 8'h00, 1'b1);
        rd(16'hc080, ERASED_BYTE);
        $display("test protect and mass erase done");
    endtask

    // Verdict and end of run
    task automatic test_done;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence after a 16-cycle reset
    initial begin
        repeat (16) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_reset;
        t_interlock;
        t_program;
        t_page;
        t_protect;
        test_done;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        test_done;
    end
endmodule // tb_top
